// *** mac_wakeup_jabber_pkg.sv ***
package mac_wakeup_jabber_pkg;
    localparam logic [7:0] ADDR_WAKE_PATTERN = 8'h70;
    localparam logic [7:0] ADDR_WDOG_JABBER = 8'h78;
    localparam logic [7:0] ADDR_AUX_STATUS = 8'h80;
    localparam logic [7:0] ADDR_AUX_IRQ_EN = 8'h84;
    localparam logic [7:0] ADDR_WAKE_READBACK = 8'h88;
    localparam int WAKE_PATTERNS = 5;
    localparam int WAKE_WORDS_PER_PATTERN = 5;
    localparam logic [4:0] WAKE_WORDS = 5'd25;
    localparam int WAKE_OFFSET_BITS = 8;
    localparam int BIT_RX_RELEASE_SEL = 5;
    localparam int BIT_RX_WDOG_OFF = 4;
    localparam int BIT_JABBER_TIME_SEL = 2;
    localparam int BIT_JABBER_IMMEDIATE = 1;
    localparam int BIT_JABBER_OFF = 0;
    localparam int BIT_TX_EARLY = 31;
    localparam int BIT_RX_EARLY = 30;
    localparam int BIT_XCVR_SUMMARY = 29;
    localparam int BIT_TX_DEFER = 28;
    localparam int BIT_PAUSE_RX = 26;
    localparam int BIT_BUS_ERR_LO = 23;
    localparam logic [31:0] IRQ_BITS_MASK = 32'hf400_0000;
    localparam logic [5:0] WDOG_JABBER_RESET = 6'h00;
    localparam logic [2:0] BUS_ERR_PARITY = 3'h0;
    localparam logic [2:0] BUS_ERR_MASTER_ABORT = 3'h1;
    localparam logic [2:0] BUS_ERR_TARGET_ABORT = 3'h2;
    // figures in their own units
    localparam int RX_RELEASE_SHORT_BITS = 24;
    localparam int RX_RELEASE_LONG_BITS = 48;
    localparam int RX_WDOG_BYTES = 2560;
    localparam int JABBER_BYTES = 2560;
    localparam int JABBER_FAST_US = 2600;
    localparam int JABBER_SLOW_US = 26000;
    localparam int REENABLE_FAST_US = 42000;
    localparam int REENABLE_SLOW_US = 420000;
    localparam int CLK_MHZ = 100;
    localparam int JABBER_FAST_CYC = JABBER_FAST_US * CLK_MHZ;
    localparam int JABBER_SLOW_CYC = JABBER_SLOW_US * CLK_MHZ;
    localparam int REENABLE_FAST_CYC = REENABLE_FAST_US * CLK_MHZ;
    localparam int REENABLE_SLOW_CYC = REENABLE_SLOW_US * CLK_MHZ;
    typedef struct packed {
        logic tx_moved;
        logic rx_first_desc;
        logic tx_deferred;
        logic pause_rx;
        logic pause_enabled;
        logic fatal_bus_error_flag;
        logic [2:0] bus_error_code;
    } mac_events_t;
    typedef struct packed {
        logic speed_100;
        logic tx_active;
        logic rx_carrier;
        logic bit_tick;
        logic byte_tick;
    } link_status_t;
endpackage

// *** mac_wakeup_jabber_status_regs.sv ***
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module mac_wakeup_jabber_status_regs
    import mac_wakeup_jabber_pkg::*;
#(
    parameter int JAB_FAST_CYC = JABBER_FAST_CYC,
    parameter int JAB_SLOW_CYC = JABBER_SLOW_CYC,
    parameter int REEN_FAST_CYC = REENABLE_FAST_CYC,
    parameter int REEN_SLOW_CYC = REENABLE_SLOW_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mac_events_t events,
    input wire link_status_t link,
    input wire logic [6:0] transceiver_irq_reg,
    output logic irq,
    output logic tx_enable,
    output logic jabber_expired,
    output logic rx_watchdog_expired,
    output logic [WAKE_PATTERNS*WAKE_WORDS_PER_PATTERN*32-1:0] wake_pattern_data
);

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] wake_mem [WAKE_WORDS];
    logic [4:0] wake_ptr;
    logic [5:0] watchdog_jabber_control;
    logic [31:0] aux_irq_enable_reg;
    logic tx_early_flag, rx_early_flag, transceiver_irq_summary, tx_defer_flag, pause_rx_flag;
    logic [2:0] bus_error_kind;
    logic [31:0] supplementary_interrupt_status;
    logic wr, rd, mapped;
    logic [31:0] next_prdata;

    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && !penable && !pwrite;
    assign mapped = paddr == ADDR_WAKE_PATTERN || paddr == ADDR_WDOG_JABBER
        || paddr == ADDR_AUX_STATUS || paddr == ADDR_AUX_IRQ_EN || paddr == ADDR_WAKE_READBACK;

    function automatic logic w1c(input logic q, input logic set, input logic clr);
        return set | (q & ~clr);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // no wait state: setup cycle decodes, access cycle answers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd) begin
                prdata <= next_prdata;
            end
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            ADDR_WDOG_JABBER: next_prdata = {26'h0, watchdog_jabber_control};
            ADDR_AUX_STATUS: next_prdata = supplementary_interrupt_status;
            ADDR_AUX_IRQ_EN: next_prdata = aux_irq_enable_reg;
            ADDR_WAKE_READBACK: next_prdata = {27'h0, wake_ptr};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // pointer wraps after the 25th word so a load after a full one starts at pattern one; a readback write also resets it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wake_ptr <= 5'h00;
        end else if (wr && paddr == ADDR_WAKE_PATTERN) begin
            wake_ptr <= (wake_ptr == WAKE_WORDS - 5'd1) ? 5'h00 : wake_ptr + 5'd1;
        end else if (wr && paddr == ADDR_WAKE_READBACK) begin
            wake_ptr <= 5'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wr && paddr == ADDR_WAKE_PATTERN) begin
            wake_mem[wake_ptr] <= pwdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < WAKE_WORDS; gi++) begin : g_wake
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    wake_pattern_data[gi*32 +: 32] <= 32'h0000_0000;
                end else if ((gi % WAKE_WORDS_PER_PATTERN) == 4) begin
                    // crc in 31:16, offset in 7:0, reserved bits forced to zero
                    wake_pattern_data[gi*32 +: 32] <= {wake_mem[gi][31:16], 8'h00,
                        wake_mem[gi][WAKE_OFFSET_BITS-1:0]};
                end else begin
                    wake_pattern_data[gi*32 +: 32] <= wake_mem[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_jabber_control <= WDOG_JABBER_RESET;
            aux_irq_enable_reg <= 32'h0000_0000;
        end else if (wr && paddr == ADDR_WDOG_JABBER) begin
            watchdog_jabber_control <= pwdata[5:0] & 6'h37;
        end else if (wr && paddr == ADDR_AUX_IRQ_EN) begin
            aux_irq_enable_reg <= pwdata & IRQ_BITS_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic clr_stat;
    assign clr_stat = wr && paddr == ADDR_AUX_STATUS;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_early_flag <= 1'b0;
            rx_early_flag <= 1'b0;
            tx_defer_flag <= 1'b0;
            pause_rx_flag <= 1'b0;
            transceiver_irq_summary <= 1'b0;
            bus_error_kind <= BUS_ERR_PARITY;
        end else begin
            tx_early_flag <= w1c(tx_early_flag,
                events.tx_moved && aux_irq_enable_reg[BIT_TX_EARLY],
                clr_stat && pwdata[BIT_TX_EARLY]);
            rx_early_flag <= w1c(rx_early_flag,
                events.rx_first_desc && aux_irq_enable_reg[BIT_RX_EARLY],
                clr_stat && pwdata[BIT_RX_EARLY]);
            tx_defer_flag <= w1c(tx_defer_flag, events.tx_deferred,
                clr_stat && pwdata[BIT_TX_DEFER]);
            pause_rx_flag <= w1c(pause_rx_flag, events.pause_rx && events.pause_enabled,
                clr_stat && pwdata[BIT_PAUSE_RX]);
            transceiver_irq_summary <= |transceiver_irq_reg;
            // captured only with the fatal flag, otherwise reads back as zero
            bus_error_kind <= events.fatal_bus_error_flag ? events.bus_error_code
                : BUS_ERR_PARITY;
        end
    end

    always_comb begin
        supplementary_interrupt_status = 32'h0000_0000;
        supplementary_interrupt_status[BIT_TX_EARLY] = tx_early_flag;
        supplementary_interrupt_status[BIT_RX_EARLY] = rx_early_flag;
        supplementary_interrupt_status[BIT_XCVR_SUMMARY] = transceiver_irq_summary;
        supplementary_interrupt_status[BIT_TX_DEFER] = tx_defer_flag;
        supplementary_interrupt_status[BIT_PAUSE_RX] = pause_rx_flag;
        supplementary_interrupt_status[BIT_BUS_ERR_LO +: 3] = bus_error_kind;
    end

    // error kind bits sit outside the mask so they cannot raise the line
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(supplementary_interrupt_status & aux_irq_enable_reg & IRQ_BITS_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive watchdog: counts bytes while carrier is up, releases after carrier drop
    logic [11:0] rx_bytes;
    logic [5:0] rx_release_bits;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_bytes <= 12'h000;
            rx_release_bits <= 6'h00;
            rx_watchdog_expired <= 1'b0;
        end else if (watchdog_jabber_control[BIT_RX_WDOG_OFF]) begin
            rx_bytes <= 12'h000;
            rx_release_bits <= 6'h00;
            rx_watchdog_expired <= 1'b0;
        end else if (link.rx_carrier) begin
            rx_release_bits <= 6'h00;
            if (link.byte_tick && rx_bytes != 12'hfff) begin
                rx_bytes <= rx_bytes + 12'd1;
            end
            if (rx_bytes >= 12'(RX_WDOG_BYTES)) begin
                rx_watchdog_expired <= 1'b1;
            end
        end else if (rx_watchdog_expired || rx_bytes != 12'h000) begin
            if (link.bit_tick) begin
                rx_release_bits <= rx_release_bits + 6'd1;
            end
            if (rx_release_bits >= (watchdog_jabber_control[BIT_RX_RELEASE_SEL]
                    ? 6'(RX_RELEASE_LONG_BITS) : 6'(RX_RELEASE_SHORT_BITS))) begin
                rx_watchdog_expired <= 1'b0;
                rx_bytes <= 12'h000;
                rx_release_bits <= 6'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit jabber: one counter serves cut-off and the re-enable hold-off
    logic [31:0] jab_cnt;
    logic [31:0] jab_limit, reen_limit;
    always_comb begin
        if (watchdog_jabber_control[BIT_JABBER_TIME_SEL]) begin
            jab_limit = 32'(JABBER_BYTES);
        end else begin
            jab_limit = link.speed_100 ? 32'(JAB_FAST_CYC) : 32'(JAB_SLOW_CYC);
        end
        reen_limit = link.speed_100 ? 32'(REEN_FAST_CYC) : 32'(REEN_SLOW_CYC);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            jab_cnt <= 32'h0000_0000;
            jabber_expired <= 1'b0;
            tx_enable <= 1'b1;
        end else if (watchdog_jabber_control[BIT_JABBER_OFF]) begin
            jab_cnt <= 32'h0000_0000;
            jabber_expired <= 1'b0;
            tx_enable <= 1'b1;
        end else if (jabber_expired) begin
            if (watchdog_jabber_control[BIT_JABBER_IMMEDIATE] || jab_cnt >= reen_limit - 32'd1) begin
                jabber_expired <= 1'b0;
                tx_enable <= 1'b1;
                jab_cnt <= 32'h0000_0000;
            end else begin
                jab_cnt <= jab_cnt + 32'd1;
            end
        end else if (link.tx_active) begin
            if (!watchdog_jabber_control[BIT_JABBER_TIME_SEL] || link.byte_tick) begin
                jab_cnt <= jab_cnt + 32'd1;
            end
            if (jab_cnt >= jab_limit) begin
                jabber_expired <= 1'b1;
                tx_enable <= 1'b0;
                jab_cnt <= 32'h0000_0000;
            end
        end else begin
            jab_cnt <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_TX_EARLY_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
        events.tx_moved && aux_irq_enable_reg[BIT_TX_EARLY] |=> tx_early_flag)
        else $error("tx early flag not set");
    AST_RX_EARLY_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
        events.rx_first_desc && aux_irq_enable_reg[BIT_RX_EARLY] |=> rx_early_flag)
        else $error("rx early flag not set");
    AST_XCVR_OR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ##1 transceiver_irq_summary == |$past(transceiver_irq_reg))
        else $error("transceiver summary wrong");
    AST_DEFER_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
        events.tx_deferred |=> tx_defer_flag)
        else $error("defer flag not set");
    AST_PAUSE_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
        events.pause_rx && events.pause_enabled |=> pause_rx_flag)
        else $error("pause flag not set");
    AST_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        pause_rx_flag && !(clr_stat && pwdata[BIT_PAUSE_RX]) |=> pause_rx_flag)
        else $error("latched flag dropped");
    AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (!arst_n)
        events.tx_deferred && clr_stat && pwdata[BIT_TX_DEFER] |=> tx_defer_flag)
        else $error("clear beat set");
    AST_BET_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !events.fatal_bus_error_flag |=> bus_error_kind == BUS_ERR_PARITY)
        else $error("bus error kind without fatal flag");
    AST_JABBER_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
        watchdog_jabber_control[BIT_JABBER_OFF] |=> tx_enable && !jabber_expired)
        else $error("jabber active while off");
    AST_NJ_IMMEDIATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        jabber_expired && watchdog_jabber_control[BIT_JABBER_IMMEDIATE] |=> tx_enable)
        else $error("no immediate re-enable");
    AST_WAKE_WRAP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr && paddr == ADDR_WAKE_PATTERN && wake_ptr == 5'd24 |=> wake_ptr == 5'd0)
        else $error("wake pointer did not wrap");
    AST_TX_EARLY_GATED: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !aux_irq_enable_reg[BIT_TX_EARLY] && !tx_early_flag |=> !tx_early_flag)
        else $error("tx early flag set while disabled");
    AST_RX_EARLY_GATED: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !aux_irq_enable_reg[BIT_RX_EARLY] && !rx_early_flag |=> !rx_early_flag)
        else $error("rx early flag set while disabled");
    AST_PAUSE_GATED: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !events.pause_enabled && !pause_rx_flag |=> !pause_rx_flag)
        else $error("pause flag set with pause function off");
    AST_TX_EARLY_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clr_stat && pwdata[BIT_TX_EARLY] && !events.tx_moved |=> !tx_early_flag)
        else $error("tx early flag not cleared by write one");
    AST_BET_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!arst_n)
        events.fatal_bus_error_flag |=> bus_error_kind == $past(events.bus_error_code))
        else $error("bus error kind not captured");
    AST_BET_NO_IRQ: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !tx_early_flag && !rx_early_flag && !transceiver_irq_summary && !tx_defer_flag
        && !pause_rx_flag |=> !irq)
        else $error("interrupt raised without a latched event");
    AST_RXWD_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
        watchdog_jabber_control[BIT_RX_WDOG_OFF] |=> !rx_watchdog_expired)
        else $error("rx watchdog active while off");
    AST_JABBER_CUTS: assert property (@(posedge clk_sys) disable iff (!arst_n)
        jabber_expired |-> !tx_enable)
        else $error("transmit enabled while jabber expired");
    AST_WAKE_STEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr && paddr == ADDR_WAKE_PATTERN && wake_ptr != 5'd24 |=> wake_ptr == $past(wake_ptr) + 5'd1)
        else $error("wake pointer did not step");
    AST_WAKE_RESERVED: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wake_pattern_data[4*32+8 +: 8] == 8'h00)
        else $error("reserved bits of crc offset word not zero");
    COV_IRQ: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(irq));
    COV_SET_CLR: cover property (@(posedge clk_sys) disable iff (!arst_n)
        events.tx_moved && aux_irq_enable_reg[BIT_TX_EARLY] && clr_stat && pwdata[BIT_TX_EARLY]);
    COV_JABBER: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(jabber_expired));
    COV_RXWD: cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(rx_watchdog_expired));
    COV_WAKE: cover property (@(posedge clk_sys) disable iff (!arst_n) wake_ptr == 5'd24);

endmodule
`default_nettype wire

// *** mac_wakeup_jabber_status_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_wakeup_jabber_status_regs_bench;
import mac_wakeup_jabber_pkg::*;
// shortened timer counts keep the run short
localparam int JF = 50;
localparam int JS = 100;
localparam int RF = 80;
localparam int RS = 160;
logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, irq;
logic tx_enable, jabber_expired, rx_watchdog_expired;
logic [7:0] paddr;
logic [31:0] pwdata, prdata, q;
logic [6:0] transceiver_irq_reg;
logic [799:0] wake_pattern_data;
mac_events_t events, lvl, e;
link_status_t link;
int fails, check_count, n, i, k;
mac_wakeup_jabber_status_regs #(.JAB_FAST_CYC(JF), .JAB_SLOW_CYC(JS), .REEN_FAST_CYC(RF),
    .REEN_SLOW_CYC(RS)) u_mac_wakeup_jabber_status_regs (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events), .link(link),
    .transceiver_irq_reg(transceiver_irq_reg), .irq(irq), .tx_enable(tx_enable),
    .jabber_expired(jabber_expired), .rx_watchdog_expired(rx_watchdog_expired),
    .wake_pattern_data(wake_pattern_data));
////////////////////////////////////////////////////////////////////////////////
task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
        fails++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic near(input int got, input int exp);
    chk(32'(got), (got >= exp - 3 && got <= exp + 3) ? 32'(got) : 32'(exp));
endtask
// pulse is laid on the events during the access cycle, so it lands on the write edge
task automatic apb(input logic w_en, input logic [7:0] a, input logic [31:0] d,
        input mac_events_t p, output logic [31:0] rdata, output logic err);
    int w;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    if (p != '0) events <= lvl | p;
    w = 0;
    do begin
        @(posedge clk_sys);
        w++;
    end while (pready !== 1'b1 && w < 16);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (p != '0) events <= lvl;
    if (w >= 16) chk(32'h0, 32'h1);
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic r;
    apb(1'b1, a, d, '0, x, r);
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic r;
    apb(1'b0, a, 32'h0, '0, x, r);
    chk(x, exp);
    chk({31'h0, r}, 32'h0);
endtask
task automatic pulse(input mac_events_t p);
    @(posedge clk_sys);
    events <= lvl | p;
    @(posedge clk_sys);
    events <= lvl;
    repeat (2) @(posedge clk_sys);
endtask
function automatic logic sig(input int s);
    case (s)
        0: return jabber_expired;
        1: return tx_enable;
        default: return rx_watchdog_expired;
    endcase
endfunction
task automatic meas(input int s, input logic v, input int lim, output int c);
    c = 0;
    while (sig(s) !== v && c < lim) begin
        @(posedge clk_sys);
        c++;
    end
endtask
task automatic jab(input logic [31:0] ctl, input logic spd, input int ej, input int er);
    int c;
    meas(0, 1'b0, 400, c);
    wr(ADDR_WDOG_JABBER, ctl);
    @(posedge clk_sys);
    link.speed_100 <= spd;
    link.tx_active <= 1'b1;
    meas(0, 1'b1, 3000, c);
    near(c, ej);
    repeat (2) @(posedge clk_sys);
    if (er > 0) chk({31'h0, tx_enable}, 32'h0);
    link.tx_active <= 1'b0;
    meas(1, 1'b1, 400, c);
    near(c + 2, er);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end
initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    stop_test();
end
initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    lvl = '0;
    events = '0;
    link = '0;
    link.bit_tick = 1'b1;
    link.byte_tick = 1'b1;
    transceiver_irq_reg = 7'h00;
    arst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({30'h0, tx_enable, irq}, 32'h2);
    arst_n <= 1'b1;
    rd(ADDR_WDOG_JABBER, 32'h0);
    rd(ADDR_AUX_STATUS, 32'h0);
    wr(ADDR_WDOG_JABBER, 32'hffff_ffff);
    rd(ADDR_WDOG_JABBER, 32'h0000_0037);
    apb(1'b0, 8'h90, 32'h0, '0, q, e[0]);
    chk({q[30:0], e[0]}, 32'h1);
    $display("test registers done");
    wr(ADDR_WAKE_READBACK, 32'h0);
    for (i = 0; i < 25; i++) wr(ADDR_WAKE_PATTERN, {i[7:0], 8'ha5, 8'h5a, 8'(i + 8'h80)});
    rd(ADDR_WAKE_READBACK, 32'h0);
    rd(ADDR_WAKE_PATTERN, 32'h0);
    for (i = 0; i < 25; i++)
        chk(wake_pattern_data[i*32+:32], {i[7:0], 8'ha5, (i % 5 == 4) ? 8'h00 : 8'h5a,
            8'(i + 8'h80)});
    wr(ADDR_WAKE_PATTERN, 32'h1);
    rd(ADDR_WAKE_READBACK, 32'h1);
    $display("test wake done");
    // early flags need their enables; deferred latches regardless
    e = '0;
    e.tx_moved = 1'b1;
    e.rx_first_desc = 1'b1;
    pulse(e);
    rd(ADDR_AUX_STATUS, 32'h0);
    wr(ADDR_AUX_IRQ_EN, 32'hffff_ffff);
    rd(ADDR_AUX_IRQ_EN, IRQ_BITS_MASK);
    for (k = 0; k < 4; k++) begin
        e = '0;
        e.pause_enabled = 1'b1;
        case (k)
            0: e.tx_moved = 1'b1;
            1: e.rx_first_desc = 1'b1;
            2: e.tx_deferred = 1'b1;
            default: e.pause_rx = 1'b1;
        endcase
        pulse(e);
        n = (k == 0) ? BIT_TX_EARLY : (k == 1) ? BIT_RX_EARLY : (k == 2) ? BIT_TX_DEFER :
            BIT_PAUSE_RX;
        repeat (5) @(posedge clk_sys);
        rd(ADDR_AUX_STATUS, 32'h1 << n);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_AUX_IRQ_EN, 32'h0);
        // irq is registered behind the enable register, one edge after the write
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_AUX_IRQ_EN, IRQ_BITS_MASK);
        wr(ADDR_AUX_STATUS, 32'h1 << n);
        rd(ADDR_AUX_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
    end
    e = '0;
    e.pause_rx = 1'b1;
    pulse(e);
    rd(ADDR_AUX_STATUS, 32'h0);
    e = '0;
    e.tx_moved = 1'b1;
    pulse(e);
    apb(1'b1, ADDR_AUX_STATUS, 32'h8000_0000, e, q, e[0]);
    rd(ADDR_AUX_STATUS, 32'h8000_0000);
    wr(ADDR_AUX_STATUS, 32'h8000_0000);
    for (i = 0; i < 7; i++) begin
        transceiver_irq_reg <= 7'(1 << i);
        rd(ADDR_AUX_STATUS, 32'h1 << BIT_XCVR_SUMMARY);
        chk({31'h0, irq}, 32'h1);
    end
    transceiver_irq_reg <= 7'h00;
    rd(ADDR_AUX_STATUS, 32'h0);
    for (k = 0; k < 3; k++) begin
        lvl.fatal_bus_error_flag = 1'b1;
        lvl.bus_error_code = (k == 0) ? BUS_ERR_PARITY : (k == 1) ? BUS_ERR_MASTER_ABORT :
            BUS_ERR_TARGET_ABORT;
        events <= lvl;
        rd(ADDR_AUX_STATUS, 32'(lvl.bus_error_code) << BIT_BUS_ERR_LO);
        chk({31'h0, irq}, 32'h0);
    end
    lvl.fatal_bus_error_flag = 1'b0;
    events <= lvl;
    rd(ADDR_AUX_STATUS, 32'h0);
    $display("test status done");
    jab(32'h0, 1'b1, JF, RF);
    jab(32'h0, 1'b0, JS, RS);
    jab(32'h2, 1'b1, JF, 0);
    jab(32'h4, 1'b1, JABBER_BYTES, RF);
    wr(ADDR_WDOG_JABBER, 32'h1);
    link.tx_active <= 1'b1;
    meas(0, 1'b1, 300, n);
    chk(32'(n) | {31'h0, ~tx_enable}, 32'd300);
    link.tx_active <= 1'b0;
    $display("test jabber done");
    for (k = 0; k < 2; k++) begin
        wr(ADDR_WDOG_JABBER, 32'(k) << BIT_RX_RELEASE_SEL);
        link.rx_carrier <= 1'b1;
        meas(2, 1'b1, 3000, n);
        near(n, RX_WDOG_BYTES);
        link.rx_carrier <= 1'b0;
        meas(2, 1'b0, 200, n);
        near(n, (k == 0) ? RX_RELEASE_SHORT_BITS : RX_RELEASE_LONG_BITS);
    end
    wr(ADDR_WDOG_JABBER, 32'h1 << BIT_RX_WDOG_OFF);
    link.rx_carrier <= 1'b1;
    meas(2, 1'b1, 3000, n);
    chk(32'(n), 32'd3000);
    $display("test watchdog done");
    stop_test();
end
endmodule
`default_nettype wire
